// file: adc_seq_pkg.sv
// Notes on behaviour
// - Ten-bit successive approximation result into result bytes
// - Positive reference is supply or external pin
// - Divider field picks system divide or RC
// - Eleven conversion periods per conversion
// - Done flag sets on every completion
// - Enabled completion in sleep requests wake interrupt
// - Justify select places result left or right
// - Converter runs only when enabled; start begins
// - Completion clears start, sets done, loads result
// - Clearing start aborts; previous result kept
// - Abort holds off acquisition two conversion periods
// - After hold-off acquisition restarts on channel
// - Reset returns all control state to defaults
// - Non-RC conversion clock derives from system clock
// - RC clock waits one instruction before converting
// - Special event trigger sets start in hardware
package adc_seq_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int unsigned RESULT_W    = 10;
  localparam logic [9:0]  RESULT_RST  = 10'h000;
  localparam logic [9:0]  TRIAL_INIT  = 10'h200;
  localparam logic [3:0]  CHANNEL_RST = 4'h0;

  // ==========================================================
  // Timing counts
  localparam logic [3:0] CONV_LAST       = 4'ha;
  localparam logic [1:0] HOLDOFF_LAST    = 2'h1;
  localparam logic [1:0] INSTR_WAIT_LAST = 2'h3;

  // ==========================================================
  // Clock divider select codes
  localparam logic [2:0] DIV_2  = 3'h0;
  localparam logic [2:0] DIV_4  = 3'h4;
  localparam logic [2:0] DIV_8  = 3'h1;
  localparam logic [2:0] DIV_16 = 3'h5;
  localparam logic [2:0] DIV_32 = 3'h2;
  localparam logic [2:0] DIV_64 = 3'h6;
  localparam logic [1:0] RC_LOW = 2'h3;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    st_idle    = 4'h1,
    st_rc_wait = 4'h2,
    st_convert = 4'h4,
    st_holdoff = 4'h8
  } state_e;

  // ==========================================================
  // Helpers
  function automatic logic rc_selected(input logic [2:0] sel);
    rc_selected = (sel[1:0] == RC_LOW);
  endfunction

  function automatic logic [5:0] term_count(input logic [2:0] sel);
    case (sel)
      DIV_2:   term_count = 6'h01;
      DIV_4:   term_count = 6'h03;
      DIV_8:   term_count = 6'h07;
      DIV_16:  term_count = 6'h0f;
      DIV_32:  term_count = 6'h1f;
      DIV_64:  term_count = 6'h3f;
      default: term_count = 6'h00;
    endcase
  endfunction

  function automatic logic [15:0] justify(input logic [9:0] res, input logic right);
    if (right) begin
      justify = {6'h00, res};
    end else begin
      justify = {res, 6'h00};
    end
  endfunction

endpackage

// file: adc_tad_tick.sv
`timescale 1ns/1ps
module adc_tad_tick (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       restart_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       rc_tick_i,
  output logic            tick_o
);

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic       sys_tick;

  // ==========================================================
  // Divider
  always_comb begin
    sys_tick = (cnt_reg == adc_seq_pkg::term_count(sel_i));
    if (restart_i || sys_tick || adc_seq_pkg::rc_selected(sel_i)) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_comb begin
    if (adc_seq_pkg::rc_selected(sel_i)) begin
      tick_o = rc_tick_i;
    end else begin
      tick_o = sys_tick && !restart_i;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_div2;
    (sel_i == adc_seq_pkg::DIV_2) && !restart_i && $stable(sel_i) && tick_o
      |=> !tick_o ##1 (tick_o || restart_i || $past(restart_i));
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two tick spacing wrong");

endmodule

// file: adc_conversion_sequencer.sv
`timescale 1ns/1ps
module adc_conversion_sequencer (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       converter_enable_i,
  input  wire logic       start_set_i,
  input  wire logic       start_clear_i,
  input  wire logic       trigger_i,
  input  wire logic       done_clear_i,
  input  wire logic       conversion_irq_enable_i,
  input  wire logic       sleep_i,
  input  wire logic       result_justify_select_i,
  input  wire logic       positive_ref_select_i,
  input  wire logic [3:0] channel_select_i,
  input  wire logic [2:0] clock_divider_select_i,
  input  wire logic       rc_tick_i,
  input  wire logic       comp_i,
  output logic            conversion_start_flag_o,
  output logic            conversion_done_flag_o,
  output logic [7:0]      result_high_byte_o,
  output logic [7:0]      result_low_byte_o,
  output logic [9:0]      dac_code_o,
  output logic            ref_external_o,
  output logic [3:0]      channel_o,
  output logic            sample_o,
  output logic            irq_o,
  output logic            wake_o
);

  adc_seq_pkg::state_e state_reg;
  adc_seq_pkg::state_e state_next;
  logic                go_reg;
  logic                go_next;
  logic                done_reg;
  logic                done_next;
  logic [9:0]          sar_reg;
  logic [9:0]          sar_next;
  logic [3:0]          bit_reg;
  logic [3:0]          bit_next;
  logic [1:0]          wait_reg;
  logic [1:0]          wait_next;
  logic [1:0]          hold_reg;
  logic [1:0]          hold_next;
  logic [9:0]          result_reg;
  logic [9:0]          result_next;
  logic [15:0]         bytes_reg;
  logic [15:0]         bytes_next;
  logic                ref_reg;
  logic [3:0]          chan_reg;

  logic                tad_tick;
  logic                restart;
  logic                rc_sel;
  logic                start_req;
  logic                abort;
  logic                complete;
  logic [3:0]          idx;
  logic [9:0]          step_code;
  logic [9:0]          phase_reg;
  logic [9:0]          phase_next;

  // ==========================================================
  // Phase count on the last cycle of a state lasting one more than the given number of conversion periods
  function automatic logic [9:0] state_span(input logic [3:0] periods, input logic [2:0] sel);
    state_span = (({6'h00, periods} + 10'h001) * ({4'h0, adc_seq_pkg::term_count(sel)} + 10'h001)) - 10'h001;
  endfunction

  // ==========================================================
  // Conversion clock
  assign restart = (state_reg == adc_seq_pkg::st_idle) || (state_reg == adc_seq_pkg::st_rc_wait)
                   || ((state_reg == adc_seq_pkg::st_convert) && abort);
  assign rc_sel  = adc_seq_pkg::rc_selected(clock_divider_select_i);

  adc_tad_tick u_tick (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .restart_i (restart),
    .sel_i     (clock_divider_select_i),
    .rc_tick_i (rc_tick_i),
    .tick_o    (tad_tick)
  );

  // ==========================================================
  // Approximation step
  always_comb begin
    idx       = adc_seq_pkg::CONV_LAST - bit_reg;
    step_code = sar_reg;
    if (bit_reg != 4'h0) begin
      step_code[idx] = comp_i;
      if (idx != 4'h0) begin
        step_code[idx - 4'h1] = 1'b1;
      end
    end
  end

  assign start_req = (start_set_i || trigger_i) && converter_enable_i;
  assign abort     = start_clear_i || (sleep_i && !rc_sel);
  assign complete  = (state_reg == adc_seq_pkg::st_convert) && tad_tick && (bit_reg == adc_seq_pkg::CONV_LAST)
                     && converter_enable_i && !abort;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next  = state_reg;
    go_next     = go_reg;
    done_next   = done_clear_i ? 1'b0 : done_reg;
    sar_next    = sar_reg;
    bit_next    = bit_reg;
    wait_next   = wait_reg;
    hold_next   = hold_reg;
    result_next = result_reg;
    unique case (state_reg)
      adc_seq_pkg::st_idle: begin
        if (start_req) begin
          go_next  = 1'b1;
          sar_next = adc_seq_pkg::TRIAL_INIT;
          bit_next = 4'h0;
          if (rc_sel) begin
            wait_next  = 2'h0;
            state_next = adc_seq_pkg::st_rc_wait;
          end else begin
            state_next = adc_seq_pkg::st_convert;
          end
        end
      end
      adc_seq_pkg::st_rc_wait: begin
        if (!converter_enable_i) begin
          go_next    = 1'b0;
          state_next = adc_seq_pkg::st_idle;
        end else if (abort) begin
          go_next    = 1'b0;
          hold_next  = 2'h0;
          state_next = adc_seq_pkg::st_holdoff;
        end else if (wait_reg == adc_seq_pkg::INSTR_WAIT_LAST) begin
          state_next = adc_seq_pkg::st_convert;
        end else begin
          wait_next = wait_reg + 2'h1;
        end
      end
      adc_seq_pkg::st_convert: begin
        if (!converter_enable_i) begin
          go_next    = 1'b0;
          state_next = adc_seq_pkg::st_idle;
        end else if (abort) begin
          go_next    = 1'b0;
          hold_next  = 2'h0;
          state_next = adc_seq_pkg::st_holdoff;
        end else if (tad_tick) begin
          if (bit_reg != 4'h0) begin
            sar_next = step_code;
          end
          if (complete) begin
            go_next     = 1'b0;
            done_next   = 1'b1;
            result_next = step_code;
            state_next  = adc_seq_pkg::st_idle;
          end else begin
            bit_next = bit_reg + 4'h1;
          end
        end
      end
      adc_seq_pkg::st_holdoff: begin
        if (!converter_enable_i) begin
          state_next = adc_seq_pkg::st_idle;
        end else if (tad_tick) begin
          if (hold_reg == adc_seq_pkg::HOLDOFF_LAST) begin
            state_next = adc_seq_pkg::st_idle;
          end else begin
            hold_next = hold_reg + 2'h1;
          end
        end
      end
      default: begin
        go_next    = 1'b0;
        state_next = adc_seq_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg  <= adc_seq_pkg::st_idle;
      go_reg     <= 1'b0;
      done_reg   <= 1'b0;
      sar_reg    <= adc_seq_pkg::RESULT_RST;
      bit_reg    <= 4'h0;
      wait_reg   <= 2'h0;
      hold_reg   <= 2'h0;
      result_reg <= adc_seq_pkg::RESULT_RST;
    end else begin
      state_reg  <= state_next;
      go_reg     <= go_next;
      done_reg   <= done_next;
      sar_reg    <= sar_next;
      bit_reg    <= bit_next;
      wait_reg   <= wait_next;
      hold_reg   <= hold_next;
      result_reg <= result_next;
    end
  end

  // ==========================================================
  // Cycles spent in the present state, for the checks
  always_comb begin
    phase_next = (state_next == state_reg) ? phase_reg + 10'h001 : 10'h000;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= 10'h000;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ==========================================================
  // Result bytes and analog routing
  always_comb begin
    bytes_next = adc_seq_pkg::justify(result_reg, result_justify_select_i);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bytes_reg <= 16'h0000;
      ref_reg   <= 1'b0;
      chan_reg  <= adc_seq_pkg::CHANNEL_RST;
    end else begin
      bytes_reg <= bytes_next;
      ref_reg   <= positive_ref_select_i;
      chan_reg  <= channel_select_i;
    end
  end

  // ==========================================================
  // Outputs
  assign conversion_start_flag_o = go_reg;
  assign conversion_done_flag_o  = done_reg;
  assign result_high_byte_o      = bytes_reg[15:8];
  assign result_low_byte_o       = bytes_reg[7:0];
  assign dac_code_o              = sar_reg;
  assign ref_external_o          = ref_reg;
  assign channel_o               = chan_reg;
  assign sample_o                = (state_reg == adc_seq_pkg::st_idle) && converter_enable_i;
  assign irq_o                   = done_reg && conversion_irq_enable_i;
  assign wake_o                  = irq_o && sleep_i;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_done_set;
    complete |=> conversion_done_flag_o;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at completion");

  property p_done_sticky;
    conversion_done_flag_o && !done_clear_i |=> conversion_done_flag_o;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag cleared by hardware");

  property p_complete;
    complete |=> !conversion_start_flag_o && (result_reg == $past(step_code));
  endproperty
  a_complete: assert property (p_complete) else $error("completion did not clear start or load result");

  property p_length;
    complete |-> (bit_reg == adc_seq_pkg::CONV_LAST)
      && (rc_sel || (phase_reg == state_span(adc_seq_pkg::CONV_LAST, clock_divider_select_i)));
  endproperty
  a_length: assert property (p_length) else $error("conversion did not last eleven periods");

  property p_abort_keep;
    (state_reg == adc_seq_pkg::st_convert) && abort && converter_enable_i
      |=> $stable(result_reg) && !conversion_start_flag_o && (state_reg == adc_seq_pkg::st_holdoff);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed result or missed hold-off");

  property p_holdoff;
    (state_reg == adc_seq_pkg::st_holdoff) && converter_enable_i
      |-> !sample_o && ((state_next != adc_seq_pkg::st_idle) || rc_sel
          || (phase_reg == state_span({2'h0, adc_seq_pkg::HOLDOFF_LAST}, clock_divider_select_i)));
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off length wrong or acquisition during hold-off");

  property p_reacquire;
    (state_reg == adc_seq_pkg::st_holdoff) && tad_tick && (hold_reg == 2'h1) && converter_enable_i
      |=> sample_o;
  endproperty
  a_reacquire: assert property (p_reacquire) else $error("acquisition not restarted after hold-off");

  property p_disabled;
    (state_reg == adc_seq_pkg::st_idle) && !converter_enable_i |=> !conversion_start_flag_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("start taken while converter disabled");

  property p_rc_wait;
    (state_reg == adc_seq_pkg::st_idle) && start_req && rc_sel
      |=> (state_reg == adc_seq_pkg::st_rc_wait) && conversion_start_flag_o;
  endproperty
  a_rc_wait: assert property (p_rc_wait) else $error("rc start skipped instruction wait");

  property p_trigger;
    (state_reg == adc_seq_pkg::st_idle) && trigger_i && converter_enable_i |=> conversion_start_flag_o;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not set start flag");

  property p_wake;
    conversion_done_flag_o && conversion_irq_enable_i && sleep_i |-> wake_o && irq_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request in sleep");

  property p_justify;
    1'b1 |=> {result_high_byte_o, result_low_byte_o}
      == adc_seq_pkg::justify($past(result_reg), $past(result_justify_select_i));
  endproperty
  a_justify: assert property (p_justify) else $error("result bytes misjustified");

endmodule

// file: adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  // ==========================================================
  // Stimulus and observed signals
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       converter_enable_i = 1'b0;
  logic       start_set_i = 1'b0;
  logic       start_clear_i = 1'b0;
  logic       trigger_i = 1'b0;
  logic       done_clear_i = 1'b0;
  logic       conversion_irq_enable_i = 1'b0;
  logic       sleep_i = 1'b0;
  logic       result_justify_select_i = 1'b0;
  logic       positive_ref_select_i = 1'b0;
  logic [3:0] channel_select_i = 4'h0;
  logic [2:0] clock_divider_select_i = 3'h0;
  logic       rc_tick_i = 1'b0;
  logic       comp_i;
  logic       conversion_start_flag_o, conversion_done_flag_o, sample_o, irq_o, wake_o, ref_external_o;
  logic [7:0] result_high_byte_o, result_low_byte_o;
  logic [9:0] dac_code_o;
  logic [3:0] channel_o;
  logic [9:0] analog_level = 10'h000;
  logic [9:0] exp_res = 10'h000;
  logic [2:0] rc_cnt = 3'h0;
  int         mismatches = 0;
  int         samples_checked = 0;
  localparam logic [2:0] DIV_CODES [6] = '{adc_seq_pkg::DIV_2, adc_seq_pkg::DIV_4, adc_seq_pkg::DIV_8,
                                           adc_seq_pkg::DIV_16, adc_seq_pkg::DIV_32, adc_seq_pkg::DIV_64};
  localparam int         DIV_N [6] = '{2, 4, 8, 16, 32, 64};
  localparam logic [9:0] LEVELS [6] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h201, 10'h1fe};

  always #50 clk_i = ~clk_i;

  // Comparator: one while the input is at or above the trial code
  assign comp_i = (analog_level >= dac_code_o);

  // Free running RC oscillator, one tick every seven system clocks
  always @(posedge clk_i) begin
    rc_cnt    <= (rc_cnt == 3'h6) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick_i <= (rc_cnt == 3'h6);
  end

  adc_conversion_sequencer i_adc_conversion_sequencer (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .converter_enable_i(converter_enable_i),
    .start_set_i(start_set_i), .start_clear_i(start_clear_i), .trigger_i(trigger_i),
    .done_clear_i(done_clear_i), .conversion_irq_enable_i(conversion_irq_enable_i), .sleep_i(sleep_i),
    .result_justify_select_i(result_justify_select_i), .positive_ref_select_i(positive_ref_select_i),
    .channel_select_i(channel_select_i), .clock_divider_select_i(clock_divider_select_i),
    .rc_tick_i(rc_tick_i), .comp_i(comp_i), .conversion_start_flag_o(conversion_start_flag_o),
    .conversion_done_flag_o(conversion_done_flag_o), .result_high_byte_o(result_high_byte_o),
    .result_low_byte_o(result_low_byte_o), .dac_code_o(dac_code_o), .ref_external_o(ref_external_o),
    .channel_o(channel_o), .sample_o(sample_o), .irq_o(irq_o), .wake_o(wake_o));

  // ==========================================================
  // Shared tasks
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task start_conv(input logic trig);
    @(posedge clk_i);
    if (trig) trigger_i <= 1'b1;
    else start_set_i <= 1'b1;
    @(posedge clk_i);
    trigger_i   <= 1'b0;
    start_set_i <= 1'b0;
    #1;
  endtask

  task clear_done;
    @(posedge clk_i);
    done_clear_i <= 1'b1;
    @(posedge clk_i);
    done_clear_i <= 1'b0;
    #1;
  endtask

  task run_conv(input logic trig, output int cycles);
    start_conv(trig);
    cycles = 0;
    while (conversion_start_flag_o === 1'b1 && cycles < 3000) begin
      step(1);
      cycles++;
    end
    if (cycles >= 3000) begin
      mismatches++;
      finish_test();
    end
  endtask

  task check_bytes;
    if (result_justify_select_i) begin
      check(result_high_byte_o, {6'h00, exp_res[9:8]});
      check(result_low_byte_o, exp_res[7:0]);
    end else begin
      check(result_high_byte_o, exp_res[9:2]);
      check(result_low_byte_o, {exp_res[1:0], 6'h00});
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_dividers;
    int cyc;
    for (int i = 0; i < 6; i++) begin
      clock_divider_select_i  <= DIV_CODES[i];
      analog_level            <= LEVELS[i];
      result_justify_select_i <= i[0];
      clear_done();
      check(conversion_done_flag_o, 1'b0);
      run_conv(i == 5, cyc);
      check(16'(cyc), 16'(11 * DIV_N[i]));
      check(conversion_done_flag_o, 1'b1);
      check(sample_o, 1'b1);
      exp_res = LEVELS[i];
      step(1);
      check_bytes();
      step(20);
      check(conversion_done_flag_o, 1'b1);
    end
  endtask

  task t_disabled_start;
    converter_enable_i <= 1'b0;
    step(1);
    check(sample_o, 1'b0);
    start_conv(1'b0);
    step(1);
    check(conversion_start_flag_o, 1'b0);
    converter_enable_i <= 1'b1;
    step(1);
  endtask

  task t_abort;
    int cnt;
    clock_divider_select_i <= adc_seq_pkg::DIV_8;
    analog_level           <= 10'h0f0;
    start_conv(1'b0);
    check(conversion_start_flag_o, 1'b1);
    step(20);
    @(posedge clk_i);
    start_clear_i <= 1'b1;
    @(posedge clk_i);
    start_clear_i <= 1'b0;
    #1;
    check(conversion_start_flag_o, 1'b0);
    check(sample_o, 1'b0);
    start_conv(1'b0);
    check(conversion_start_flag_o, 1'b0);
    cnt = 2;
    while (sample_o !== 1'b1 && cnt < 40) begin
      step(1);
      cnt++;
    end
    check(16'(cnt), 16'(2 * DIV_N[2]));
    check(sample_o, 1'b1);
    check_bytes();
    start_conv(1'b0);
    sleep_i <= 1'b1;
    step(1);
    sleep_i <= 1'b0;
    check(conversion_start_flag_o, 1'b0);
    check_bytes();
    step(15);
    check(sample_o, 1'b0);
    step(1);
    check(sample_o, 1'b1);
  endtask

  task t_rc_sleep;
    int cyc;
    for (int i = 0; i < 2; i++) begin
      clock_divider_select_i  <= i ? 3'h7 : 3'h3;
      analog_level            <= i ? 10'h2c3 : 10'h13c;
      conversion_irq_enable_i <= 1'b1;
      sleep_i                 <= 1'b1;
      clear_done();
      check(wake_o, 1'b0);
      run_conv(1'b0, cyc);
      check(cyc >= 75 && cyc <= 81, 1'b1);
      check(irq_o, 1'b1);
      check(wake_o, 1'b1);
      exp_res = i ? 10'h2c3 : 10'h13c;
      sleep_i                 <= 1'b0;
      conversion_irq_enable_i <= 1'b0;
      step(2);
      check(wake_o, 1'b0);
      check(irq_o, 1'b0);
      check_bytes();
    end
  endtask

  task t_copies;
    positive_ref_select_i <= 1'b1;
    channel_select_i      <= 4'h5;
    step(2);
    check(ref_external_o, 1'b1);
    check(channel_o, 4'h5);
    positive_ref_select_i <= 1'b0;
    channel_select_i      <= 4'ha;
    step(2);
    check(ref_external_o, 1'b0);
    check(channel_o, 4'ha);
  endtask

  task t_mid_reset;
    start_conv(1'b0);
    step(10);
    reset_n_i <= 1'b0;
    step(1);
    check(conversion_start_flag_o, 1'b0);
    check(conversion_done_flag_o, 1'b0);
    check({result_high_byte_o, result_low_byte_o}, 16'h0000);
    step(12);
    reset_n_i <= 1'b1;
    step(2);
    check(conversion_start_flag_o, 1'b0);
    check(sample_o, 1'b1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    step(12);
    check(conversion_start_flag_o, 1'b0);
    check(conversion_done_flag_o, 1'b0);
    check(dac_code_o, 10'h000);
    check(sample_o, 1'b0);
    reset_n_i <= 1'b1;
    step(2);
    converter_enable_i <= 1'b1;
    step(2);
    t_dividers();
    t_disabled_start();
    t_abort();
    t_rc_sleep();
    t_copies();
    t_mid_reset();
    finish_test();
  end
endmodule
